// *** rtl/pavr_regs.sv ***
// Picture-adjust registers and blanking-data request logic of the video decoder.
module pavr_regs
  import pavr_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // Register access from the serial control bus engine
  input  wire pavr_pkg::pavr_bus_t bus_i,
  output logic [7:0]             rdata_o,
  // Decoded blanking data from the slicers
  input  wire pavr_pkg::pavr_vbi_t caption_i,
  input  wire pavr_pkg::pavr_vbi_t extended_i,
  input  wire pavr_pkg::pavr_vbi_t copyid_i,
  // Settings to the picture datapath
  output pavr_pkg::pavr_pic_t    pic_o,
  output logic [2:0]             luma_chroma_skew_select_o,
  // Slicer arming and stored data
  output logic [2:0]             decode_armed_o,
  output logic [15:0]            caption_data_o,
  output logic [15:0]            extended_data_o,
  output logic [15:0]            copy_generation_id_o,
  output logic [2:0]             ready_flags_o
);
  import pavr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings registers.

  logic [7:0] brightness_offset_r;
  logic [7:0] brightness_offset_nxt;
  logic [7:0] saturation_gain_r;
  logic [7:0] saturation_gain_nxt;
  logic [7:0] hue_rotation_r;
  logic [7:0] hue_rotation_nxt;
  logic [2:0] luma_chroma_skew_select_r;
  logic [2:0] luma_chroma_skew_select_nxt;

  function automatic logic hit(input pavr_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  always_comb
  begin
    brightness_offset_nxt       = brightness_offset_r;
    saturation_gain_nxt         = saturation_gain_r;
    hue_rotation_nxt            = hue_rotation_r;
    luma_chroma_skew_select_nxt = luma_chroma_skew_select_r;
    if (hit(bus_i, PAVR_ADR_BRIGHT))
    begin
      brightness_offset_nxt = bus_i.wdata;
    end
    else if (hit(bus_i, PAVR_ADR_SAT))
    begin
      saturation_gain_nxt = bus_i.wdata;
    end
    else if (hit(bus_i, PAVR_ADR_HUE))
    begin
      hue_rotation_nxt = bus_i.wdata;
    end
    else if (hit(bus_i, PAVR_ADR_SKEW))
    begin
      luma_chroma_skew_select_nxt = bus_i.wdata[PAVR_SKEW_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      brightness_offset_r       <= PAVR_RST_BRIGHT;
      saturation_gain_r         <= PAVR_RST_SAT;
      hue_rotation_r            <= PAVR_RST_HUE;
      luma_chroma_skew_select_r <= PAVR_RST_SKEW[PAVR_SKEW_W-1:0];
    end
    else
    begin
      brightness_offset_r       <= brightness_offset_nxt;
      saturation_gain_r         <= saturation_gain_nxt;
      hue_rotation_r            <= hue_rotation_nxt;
      luma_chroma_skew_select_r <= luma_chroma_skew_select_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request register: write-only, one strobe per kind.

  logic       req_wr;
  logic [2:0] arm;
  logic       clear_all;

  assign req_wr    = hit(bus_i, PAVR_ADR_REQ);
  assign arm[PAVR_BIT_CAPTION]  = req_wr && bus_i.wdata[PAVR_BIT_CAPTION];
  assign arm[PAVR_BIT_EXTENDED] = req_wr && bus_i.wdata[PAVR_BIT_EXTENDED];
  assign arm[PAVR_BIT_COPYID]   = req_wr && bus_i.wdata[PAVR_BIT_COPYID];
  assign clear_all = |arm;

  pavr_vbi_t  slot_in [PAVR_NKIND];
  logic [15:0] slot_data [PAVR_NKIND];
  logic [2:0] flags;

  assign slot_in[PAVR_BIT_CAPTION]  = caption_i;
  assign slot_in[PAVR_BIT_EXTENDED] = extended_i;
  assign slot_in[PAVR_BIT_COPYID]   = copyid_i;

  for (genvar k = 0; k < PAVR_NKIND; k++)
  begin : g_slot
    pavr_decode_slot u_slot (
      .sys_clk_i    (sys_clk_i),
      .resetn_i     (resetn_i),
      .arm_i        (arm[k]),
      .clear_i      (clear_all),
      .decode_i     (slot_in[k]),
      .ready_flag_o (flags[k]),
      .armed_o      (decode_armed_o[k]),
      .data_o       (slot_data[k])
    );
  end

  assign caption_data_o       = slot_data[PAVR_BIT_CAPTION];
  assign extended_data_o      = slot_data[PAVR_BIT_EXTENDED];
  assign copy_generation_id_o = slot_data[PAVR_BIT_COPYID];
  assign ready_flags_o        = flags;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings presented to the picture datapath.

  logic signed [2:0] skew_steps;

  pavr_skew_map u_skew (
    .code_i  (luma_chroma_skew_select_r),
    .steps_o (skew_steps)
  );

  function automatic logic signed [7:0] clamp_hue(input logic signed [7:0] v);
    if (v < PAVR_HUE_NEG)
    begin
      clamp_hue = PAVR_HUE_NEG;
    end
    else
    begin
      clamp_hue = v;
    end
  endfunction

  always_comb
  begin
    pic_o.luma_offset = signed'(brightness_offset_r);
    pic_o.chroma_gain = saturation_gain_r;
    pic_o.hue_step    = clamp_hue(signed'(hue_rotation_r));
    pic_o.luma_skew   = skew_steps;
  end

  assign luma_chroma_skew_select_o = luma_chroma_skew_select_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back, registered one cycle after the read strobe.

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (bus_i.rd)
    begin
      if (bus_i.addr == PAVR_ADR_BRIGHT)
      begin
        rdata_nxt = brightness_offset_r;
      end
      else if (bus_i.addr == PAVR_ADR_SAT)
      begin
        rdata_nxt = saturation_gain_r;
      end
      else if (bus_i.addr == PAVR_ADR_HUE)
      begin
        rdata_nxt = hue_rotation_r;
      end
      else if (bus_i.addr == PAVR_ADR_SKEW)
      begin
        rdata_nxt = {5'h00, luma_chroma_skew_select_r};
      end
      else if (bus_i.addr == PAVR_ADR_STATUS)
      begin
        rdata_nxt = {flags, 5'h00};
      end
      else
      begin
        rdata_nxt = PAVR_RD_NONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_r <= PAVR_RD_NONE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule // pavr_regs

// *** shared/pavr_pkg.sv ***
// Package of constants and types for the picture-adjust and blanking-data request registers.
// Summary of operation
// - Brightness is a signed offset on luminance; resets to zero, meaning no change.
// - Saturation is an unsigned chroma gain of code over 128; zero removes colour.
// - Saturation sits at sub-address 0x08 and resets to 0x80, unity gain.
// - Hue is a signed phase rotation, about 0.35 degree a step, clamped to 45.
// - Request register is write-only; caption bit 0, extended bit 1, copy-ID bit 2.
// - Writing a one to a request bit arms that decode and waits for data.
// - A finished decode stores its two bytes and sets its ready flag.
// - Writing a one to any request bit clears all three ready flags.
// - Caption, extended data and copy-generation ID are served.
// - Skew register at 0x0b holds a 3-bit select in bits 2 to 0, resets 0x00.
// - Ready flags are read-only bits 5, 6, 7 of the status register at 0x10.
// - Codes 101/110/111 delay luma 3/2/1, 000 none, 001-011 advance luma.
// - One skew step is one pixel clock of the selected output mode.
package pavr_pkg;

  localparam int         PAVR_AW            = 8;
  localparam int         PAVR_DW            = 8;
  localparam int         PAVR_NKIND         = 3;
  localparam int         PAVR_SKEW_W        = 3;
  localparam int         PAVR_SKEW_MAX      = 3;

  localparam logic [7:0] PAVR_ADR_BRIGHT    = 8'h07;
  localparam logic [7:0] PAVR_ADR_SAT       = 8'h08;
  localparam logic [7:0] PAVR_ADR_HUE       = 8'h09;
  localparam logic [7:0] PAVR_ADR_REQ       = 8'h0a;
  localparam logic [7:0] PAVR_ADR_SKEW      = 8'h0b;
  localparam logic [7:0] PAVR_ADR_STATUS    = 8'h10;

  localparam logic [7:0] PAVR_RST_BRIGHT    = 8'h00;
  localparam logic [7:0] PAVR_RST_SAT       = 8'h80;
  localparam logic [7:0] PAVR_RST_HUE       = 8'h00;
  localparam logic [7:0] PAVR_RST_SKEW      = 8'h00;
  localparam logic [7:0] PAVR_RD_NONE       = 8'h00;

  localparam int         PAVR_BIT_CAPTION   = 0;
  localparam int         PAVR_BIT_EXTENDED  = 1;
  localparam int         PAVR_BIT_COPYID    = 2;
  localparam int         PAVR_STAT_FLAG_LSB = 5;

  // Hue limit: 45 degrees at about 0.35 degree a step gives 127 steps.
  localparam logic signed [7:0] PAVR_HUE_POS = 8'sh7f;
  localparam logic signed [7:0] PAVR_HUE_NEG = -8'sh7f;

  localparam logic [2:0] PAVR_SKEW_NONE     = 3'h0;
  localparam logic [2:0] PAVR_SKEW_ADV1     = 3'h1;
  localparam logic [2:0] PAVR_SKEW_ADV2     = 3'h2;
  localparam logic [2:0] PAVR_SKEW_ADV3     = 3'h3;
  localparam logic [2:0] PAVR_SKEW_DLY3     = 3'h5;
  localparam logic [2:0] PAVR_SKEW_DLY2     = 3'h6;
  localparam logic [2:0] PAVR_SKEW_DLY1     = 3'h7;
  localparam int         PAVR_ADV_STEPS     = 2;

  typedef enum logic [1:0] {
    PAVR_ARM_IDLE  = 2'b00,
    PAVR_ARM_WAIT  = 2'b01,
    PAVR_ARM_DONE  = 2'b10
  } pavr_arm_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pavr_bus_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } pavr_vbi_t;

  typedef struct packed {
    logic signed [7:0] luma_offset;
    logic        [7:0] chroma_gain;
    logic signed [7:0] hue_step;
    logic signed [2:0] luma_skew;
  } pavr_pic_t;

endpackage : pavr_pkg

// *** rtl/pavr_decode_slot.sv ***
// One blanking-data decode slot: arms on request, captures a decode and holds its ready flag.
module pavr_decode_slot
  import pavr_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  // Control
  input  wire logic             arm_i,
  input  wire logic             clear_i,
  input  wire pavr_pkg::pavr_vbi_t decode_i,
  // Results
  output logic                  ready_flag_o,
  output logic                  armed_o,
  output logic [15:0]           data_o
);
  import pavr_pkg::*;

  pavr_arm_t   state_r;
  pavr_arm_t   state_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;

  always_comb
  begin
    state_nxt = state_r;
    data_nxt  = data_r;
    case (state_r)
      PAVR_ARM_IDLE:
      begin
        if (arm_i)
        begin
          state_nxt = PAVR_ARM_WAIT;
        end
      end
      PAVR_ARM_WAIT:
      begin
        if (decode_i.valid)
        begin
          data_nxt  = {decode_i.byte2, decode_i.byte1};
          state_nxt = PAVR_ARM_DONE;
        end
      end
      PAVR_ARM_DONE:
      begin
        if (clear_i)
        begin
          state_nxt = PAVR_ARM_IDLE;
        end
        if (arm_i)
        begin
          state_nxt = PAVR_ARM_WAIT;
        end
      end
      default:
      begin
        state_nxt = PAVR_ARM_IDLE;
      end
    endcase
    // A new request in WAIT simply stays armed.
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      state_r <= PAVR_ARM_IDLE;
      data_r  <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      data_r  <= data_nxt;
    end
  end

  assign ready_flag_o = (state_r == PAVR_ARM_DONE);
  assign armed_o      = (state_r == PAVR_ARM_WAIT);
  assign data_o       = data_r;

endmodule // pavr_decode_slot

// *** rtl/pavr_skew_map.sv ***
// Maps the luma-chroma skew select code to a signed step count.
module pavr_skew_map
  import pavr_pkg::*;
(
  // Code in
  input  wire logic [2:0]        code_i,
  // Signed steps out: positive delays luma, negative advances it
  output logic signed [2:0]      steps_o
);
  import pavr_pkg::*;

  always_comb
  begin
    if (code_i == PAVR_SKEW_DLY3)
    begin
      steps_o = 3'sd3;
    end
    else if (code_i == PAVR_SKEW_DLY2)
    begin
      steps_o = 3'sd2;
    end
    else if (code_i == PAVR_SKEW_DLY1)
    begin
      steps_o = 3'sd1;
    end
    else if ((code_i == PAVR_SKEW_ADV1) || (code_i == PAVR_SKEW_ADV2) ||
             (code_i == PAVR_SKEW_ADV3))
    begin
      steps_o = -3'sd2;
    end
    else
    begin
      steps_o = 3'sd0;
    end
  end

endmodule // pavr_skew_map

// *** verification/pavr_regs_sva.sv ***
// Checker of the picture-adjust and blanking-data request registers.
module pavr_regs_sva
  import pavr_pkg::*;
(
  // Watched ports
  input wire logic                sys_clk_i,
  input wire logic                resetn_i,
  input wire pavr_pkg::pavr_bus_t bus_i,
  input wire logic [7:0]          rdata_o,
  input wire pavr_pkg::pavr_vbi_t caption_i,
  input wire pavr_pkg::pavr_vbi_t extended_i,
  input wire pavr_pkg::pavr_vbi_t copyid_i,
  input wire pavr_pkg::pavr_pic_t pic_o,
  input wire logic [2:0]          luma_chroma_skew_select_o,
  input wire logic [2:0]          decode_armed_o,
  input wire logic [15:0]         caption_data_o,
  input wire logic [2:0]          ready_flags_o
);
  logic       req_wr;
  logic       any_vld;
  logic [2:0] sel;
  assign req_wr  = bus_i.wr && bus_i.addr == PAVR_ADR_REQ;
  assign any_vld = caption_i.valid || extended_i.valid || copyid_i.valid;
  assign sel     = luma_chroma_skew_select_o;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  req_clear_a: assert property (
    req_wr && |bus_i.wdata[2:0] && !any_vld |=> ready_flags_o == 3'h0)
    else $error("flags not cleared by request");
  req_arm_a: assert property (
    req_wr && bus_i.wdata[0] && !caption_i.valid |=> decode_armed_o[0])
    else $error("caption slot not armed");
  cap_store_a: assert property (
    decode_armed_o[0] && caption_i.valid && !req_wr |=> ready_flags_o[0] && !decode_armed_o[0]
    && caption_data_o == $past({caption_i.byte2, caption_i.byte1}))
    else $error("caption decode not stored");
  status_read_a: assert property (
    bus_i.rd && bus_i.addr == PAVR_ADR_STATUS |=> rdata_o == {$past(ready_flags_o), 5'h00})
    else $error("status read wrong");
  req_read_a: assert property (
    bus_i.rd && bus_i.addr == PAVR_ADR_REQ |=> rdata_o == 8'h00)
    else $error("request register readable");
  bright_write_a: assert property (
    bus_i.wr && bus_i.addr == PAVR_ADR_BRIGHT |=> pic_o.luma_offset == $past(bus_i.wdata))
    else $error("brightness offset not written");
  hue_write_a: assert property (
    bus_i.wr && bus_i.addr == PAVR_ADR_HUE && bus_i.wdata != 8'h80
    |=> pic_o.hue_step == $past(bus_i.wdata))
    else $error("hue step not written");
  sat_write_a: assert property (
    bus_i.wr && bus_i.addr == PAVR_ADR_SAT |=> pic_o.chroma_gain == $past(bus_i.wdata))
    else $error("gain not written");
  skew_write_a: assert property (
    bus_i.wr && bus_i.addr == PAVR_ADR_SKEW |=> sel == $past(bus_i.wdata[2:0]))
    else $error("skew select not written");
  skew_delay_a: assert property (
    sel[2] |-> $unsigned(pic_o.luma_skew) == (sel == 3'h4 ? 3'h0 : 3'h0 - sel))
    else $error("luma delay steps wrong");
  skew_adv_a: assert property (
    !sel[2] |-> $unsigned(pic_o.luma_skew) == (sel == 3'h0 ? 3'h0 : 3'h6))
    else $error("luma advance steps wrong");
endmodule // pavr_regs_sva

bind pavr_regs pavr_regs_sva pavr_regs_sva_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .caption_i(caption_i), .extended_i(extended_i), .copyid_i(copyid_i), .pic_o(pic_o),
  .luma_chroma_skew_select_o(luma_chroma_skew_select_o), .decode_armed_o(decode_armed_o),
  .caption_data_o(caption_data_o), .ready_flags_o(ready_flags_o));

// *** verification/pavr_slicer_model.sv ***
// Model of the blanking-data slicers that feed the three decode slots.
module pavr_slicer_model
  import pavr_pkg::*;
(
  // Clock and command
  input  wire logic [0:0]     sys_clk_i,
  input  wire logic [2:0]     send_i,
  input  wire logic [15:0]    pair_i,
  // Decode results
  output pavr_pkg::pavr_vbi_t vbi_o [3]
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    foreach (vbi_o[k]) vbi_o[k] = '0;
  end
  // Bytes flip outside the valid cycle so stale data is never mistaken for a decode.
  always @(posedge sys_clk_i)
  begin
    for (int k = 0; k < 3; k++)
    begin
      vbi_o[k].valid <= send_i[k];
      {vbi_o[k].byte2, vbi_o[k].byte1} <= send_i[k] ? pair_i : ~{vbi_o[k].byte2, vbi_o[k].byte1};
    end
  end
endmodule // pavr_slicer_model

// *** verification/pavr_regs_tb_top.sv ***
// Self-checking testbench of the picture-adjust and blanking-data request registers.
module pavr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pavr_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  pavr_bus_t   bus_i     = '0;
  logic [2:0]  send      = 3'h0;
  logic [15:0] pair      = 16'h0;
  logic [7:0]  rdata_o;
  pavr_vbi_t   vbi [3];
  pavr_pic_t   pic_o;
  logic [2:0]  skew, armed, flags;
  logic [15:0] cap_d, ext_d, cid_d;
  int          num_errors   = 0;
  int          total_checks = 0;
  logic [23:0] rows [11] = '{24'h078080, 24'h08ffff, 24'h080000, 24'h098181, 24'h0bff07,
                            24'h0b0505, 24'h0b0202, 24'h0b0606, 24'h0a0000, 24'h205500,
                            24'h105500};
  logic [15:0] rst_rows [5] = '{16'h0700, 16'h0880, 16'h0900, 16'h0b00, 16'h1000};

  always #50 sys_clk_i = ~sys_clk_i;

  pavr_regs pavr_regs_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .caption_i(vbi[0]), .extended_i(vbi[1]), .copyid_i(vbi[2]),
    .pic_o(pic_o), .luma_chroma_skew_select_o(skew), .decode_armed_o(armed),
    .caption_data_o(cap_d), .extended_data_o(ext_d), .copy_generation_id_o(cid_d),
    .ready_flags_o(flags));
  pavr_slicer_model pavr_slicer_model_i (.sys_clk_i(sys_clk_i), .send_i(send),
    .pair_i(pair), .vbi_o(vbi));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    bus_i <= '0;
    @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    bus_i <= '0;
    @(negedge sys_clk_i);
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask

  task automatic put(input logic [2:0] m, input logic [15:0] p);
    @(posedge sys_clk_i);
    send <= m;
    pair <= p;
    @(posedge sys_clk_i);
    send <= 3'h0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    foreach (rows[k])
    begin
      wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16], rows[k][7:0]);
    end
    chk({13'h0, pic_o.luma_skew}, 16'h0002);
    $display("register table done");
    wr(PAVR_ADR_HUE, 8'h80);
    chk({8'h00, pic_o.hue_step}, 16'h0081);
    wr(PAVR_ADR_REQ, 8'h07);
    chk({13'h0, armed}, 16'h0007);
    put(3'h7, 16'hb2a1);
    chk({10'h0, flags, armed}, 16'h0038);
    chk(cap_d, 16'hb2a1);
    chk(ext_d, 16'hb2a1);
    chk(cid_d, 16'hb2a1);
    rd(PAVR_ADR_STATUS, 8'he0);
    put(3'h7, 16'h1234);
    chk(cap_d, 16'hb2a1);
    wr(PAVR_ADR_REQ, 8'h00);
    rd(PAVR_ADR_STATUS, 8'he0);
    wr(PAVR_ADR_REQ, 8'h02);
    chk({10'h0, flags, armed}, 16'h0002);
    put(3'h2, 16'h5a3c);
    chk(ext_d, 16'h5a3c);
    rd(PAVR_ADR_STATUS, 8'h40);
    $display("blanking request done");
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    foreach (rst_rows[k])
      rd(rst_rows[k][15:8], rst_rows[k][7:0]);
    chk({10'h0, flags, armed}, 16'h0000);
    $display("reset done");
    end_of_test();
  end
endmodule // pavr_regs_tb_top
